// >>> core/sfb_flag_bank.sv
// module: special flag bank with apb register access
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module sfb_flag_bank #(
    parameter longint unsigned REPEAT_CYCLES = sfb_pkg::SNTP_REPEAT_CYCLES
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt enable states from the cpu
    input wire logic [sfb_pkg::N_IRQ-1:0] irq_enable,
    input wire logic timer_irq_enable,
    // compare instruction execution
    input wire sfb_pkg::sfb_cmp_req_t cmp_req,
    // catch inputs and scan marker
    input wire logic [sfb_pkg::N_IRQ-1:0] catch_in,
    input wire logic scan_start,
    // connection states
    input wire sfb_pkg::sfb_conn_t conn_state,
    // sntp calendar and clock words
    input wire sfb_pkg::sfb_time_words_t sntp_time_words,
    // receive cancels and connection closes
    output sfb_pkg::sfb_cancel_t receive_cancel,
    output logic [sfb_pkg::N_CLIENT-1:0] client_close,
    // interrupt edge selection
    output logic [sfb_pkg::N_IRQ-1:0] irq_edge_select,
    // active network configuration
    output logic [31:0] net_config,
    output logic net_apply,
    // clock cartridge write port
    output logic cart_write,
    output sfb_pkg::sfb_time_words_t new_calendar_words
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [sfb_pkg::N_IRQ-1:0] irq_input_enable_status_r;
    logic timer_irq_enable_status_r;
    logic compare_greater_flag_r;
    logic compare_equal_flag_r;
    logic compare_less_flag_r;
    logic [sfb_pkg::N_IRQ-1:0] catch_input_level_flag_r;
    logic [sfb_pkg::N_IRQ-1:0] catch_prev_r;
    logic [sfb_pkg::N_IRQ-1:0] catch_taken_r;
    sfb_pkg::sfb_conn_t conn_r;
    logic [sfb_pkg::N_CLIENT-1:0] client_disconnect_request_r;
    logic sntp_clock_write_trigger_r;
    logic [31:0] network_setting_words_r;
    logic sntp_fire;
    logic wr_en;
    logic setup;
    logic [31:0] rd_nxt;
    logic map_hit;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a == sfb_pkg::OFS_IRQ_STATUS) || (a == sfb_pkg::OFS_CMP_RESULT)
            || (a == sfb_pkg::OFS_CATCH) || (a == sfb_pkg::OFS_CANCEL)
            || (a == sfb_pkg::OFS_CTRL) || (a == sfb_pkg::OFS_CONN)
            || (a == sfb_pkg::OFS_DISCONNECT) || (a == sfb_pkg::OFS_NET_WORDS);
    endfunction

    function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] ofs, input logic en);
        wr_hit = en && (a == ofs);
    endfunction

    // ------------------------------------------------------------
    // apb slave: zero wait states, answer prepared in the setup cycle
    // ------------------------------------------------------------
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite;
    assign map_hit = addr_known(paddr);

    always_comb
    begin
        rd_nxt = sfb_pkg::RST_WORD;
        unique case (paddr)
            sfb_pkg::OFS_IRQ_STATUS:
            begin
                rd_nxt[sfb_pkg::N_IRQ-1:0] = irq_input_enable_status_r;
                rd_nxt[sfb_pkg::POS_TIMER_IRQ] = timer_irq_enable_status_r;
            end
            sfb_pkg::OFS_CMP_RESULT:
            begin
                rd_nxt[sfb_pkg::POS_CMP_GREATER] = compare_greater_flag_r;
                rd_nxt[sfb_pkg::POS_CMP_EQUAL] = compare_equal_flag_r;
                rd_nxt[sfb_pkg::POS_CMP_LESS] = compare_less_flag_r;
            end
            sfb_pkg::OFS_CATCH:
                rd_nxt[sfb_pkg::N_IRQ-1:0] = catch_input_level_flag_r;
            sfb_pkg::OFS_CANCEL:
            begin
                rd_nxt[sfb_pkg::POS_CANCEL_SERIAL +: sfb_pkg::N_SERIAL] = receive_cancel.serial;
                rd_nxt[sfb_pkg::POS_CANCEL_CLIENT +: sfb_pkg::N_CLIENT] = receive_cancel.client;
                rd_nxt[sfb_pkg::POS_CANCEL_SERVER +: sfb_pkg::N_SERVER] = receive_cancel.server;
            end
            sfb_pkg::OFS_CTRL:
            begin
                rd_nxt[sfb_pkg::POS_SNTP_WRITE] = sntp_clock_write_trigger_r;
                rd_nxt[sfb_pkg::POS_EDGE_SEL +: sfb_pkg::N_IRQ] = irq_edge_select;
            end
            sfb_pkg::OFS_CONN:
            begin
                rd_nxt[sfb_pkg::N_MAINT-1:0] = conn_r.maint_server_in_use;
                rd_nxt[sfb_pkg::POS_CONN_CLIENT +: sfb_pkg::N_CLIENT] = conn_r.client_conn_in_use;
                rd_nxt[sfb_pkg::POS_CONN_SERVER +: sfb_pkg::N_SERVER] = conn_r.server_conn_in_use;
            end
            sfb_pkg::OFS_DISCONNECT:
                rd_nxt[sfb_pkg::N_CLIENT-1:0] = client_disconnect_request_r;
            sfb_pkg::OFS_NET_WORDS:
                rd_nxt = network_setting_words_r;
            default:
                rd_nxt = sfb_pkg::RST_WORD;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= sfb_pkg::RST_WORD;
        end
        else if (setup)
        begin
            pready <= 1'b1;
            pslverr <= !map_hit;
            prdata <= pwrite ? sfb_pkg::RST_WORD : rd_nxt;
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= sfb_pkg::RST_WORD;
        end
    end

    // ------------------------------------------------------------
    // interrupt enable status
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            irq_input_enable_status_r <= '0;
            timer_irq_enable_status_r <= 1'b0;
        end
        else
        begin
            irq_input_enable_status_r <= irq_enable;
            timer_irq_enable_status_r <= timer_irq_enable;
        end
    end

    // ------------------------------------------------------------
    // compare results
    // ------------------------------------------------------------
    // each execution rewrites all three flags so a stale result never lingers
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            compare_greater_flag_r <= 1'b0;
            compare_equal_flag_r <= 1'b0;
            compare_less_flag_r <= 1'b0;
        end
        else if (cmp_req.valid && cmp_req.op == sfb_pkg::SFB_OP_WORD)
        begin
            compare_greater_flag_r <= cmp_req.first_source_operand > cmp_req.second_source_operand;
            compare_equal_flag_r <= cmp_req.first_source_operand == cmp_req.second_source_operand;
            compare_less_flag_r <= cmp_req.first_source_operand < cmp_req.second_source_operand;
        end
        else if (cmp_req.valid)
        begin
            compare_greater_flag_r <= cmp_req.second_source_operand > cmp_req.first_source_operand;
            compare_equal_flag_r <= cmp_req.third_source_operand > cmp_req.second_source_operand;
            compare_less_flag_r <= (cmp_req.second_source_operand < cmp_req.first_source_operand)
                && (cmp_req.second_source_operand > cmp_req.third_source_operand);
        end
    end

    // ------------------------------------------------------------
    // catch inputs
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            catch_prev_r <= '0;
        else
            catch_prev_r <= catch_in;
    end

    // an edge in the scan_start cycle opens the new scan and is still taken
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            catch_input_level_flag_r <= '0;
            catch_taken_r <= '0;
        end
        else
        begin
            for (int i = 0; i < sfb_pkg::N_IRQ; i++)
            begin
                if ((catch_in[i] != catch_prev_r[i]) && (scan_start || !catch_taken_r[i]))
                begin
                    catch_input_level_flag_r[i] <= catch_in[i];
                    catch_taken_r[i] <= 1'b1;
                end
                else if (scan_start)
                    catch_taken_r[i] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // connection status
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            conn_r <= '0;
        else
        begin
            conn_r.maint_server_in_use <= conn_state.maint_server_in_use;
            conn_r.client_conn_in_use <= conn_state.client_conn_in_use;
            conn_r.server_conn_in_use <= conn_state.server_conn_in_use;
        end
    end

    // ------------------------------------------------------------
    // receive cancel flags: level, held until software clears them
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            receive_cancel <= '0;
        else if (wr_hit(paddr, sfb_pkg::OFS_CANCEL, wr_en))
        begin
            receive_cancel.serial <= pwdata[sfb_pkg::POS_CANCEL_SERIAL +: sfb_pkg::N_SERIAL];
            receive_cancel.client <= pwdata[sfb_pkg::POS_CANCEL_CLIENT +: sfb_pkg::N_CLIENT];
            receive_cancel.server <= pwdata[sfb_pkg::POS_CANCEL_SERVER +: sfb_pkg::N_SERVER];
        end
    end

    // ------------------------------------------------------------
    // client disconnect
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            client_disconnect_request_r <= '0;
        else if (wr_hit(paddr, sfb_pkg::OFS_DISCONNECT, wr_en))
            client_disconnect_request_r <= pwdata[sfb_pkg::N_CLIENT-1:0];
    end

    // a request against an idle connection does nothing
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            client_close <= '0;
        else
            client_close <= client_disconnect_request_r & conn_r.client_conn_in_use;
    end

    // ------------------------------------------------------------
    // control: edge select, sntp write flag, network update
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            irq_edge_select <= '0;
            sntp_clock_write_trigger_r <= 1'b0;
        end
        else if (wr_hit(paddr, sfb_pkg::OFS_CTRL, wr_en))
        begin
            irq_edge_select <= pwdata[sfb_pkg::POS_EDGE_SEL +: sfb_pkg::N_IRQ];
            sntp_clock_write_trigger_r <= pwdata[sfb_pkg::POS_SNTP_WRITE];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            network_setting_words_r <= sfb_pkg::RST_WORD;
        else if (wr_hit(paddr, sfb_pkg::OFS_NET_WORDS, wr_en))
            network_setting_words_r <= pwdata;
    end

    // the update flag is a one-shot: it never reads back as set
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            net_apply <= 1'b0;
            net_config <= sfb_pkg::RST_WORD;
        end
        else
        begin
            net_apply <= wr_hit(paddr, sfb_pkg::OFS_CTRL, wr_en) && pwdata[sfb_pkg::POS_NET_UPDATE];
            if (net_apply)
                net_config <= network_setting_words_r;
        end
    end

    // ------------------------------------------------------------
    // sntp calendar and clock copy to the cartridge
    // ------------------------------------------------------------
    sfb_repeat_timer #(
        .REPEAT_CYCLES(REPEAT_CYCLES)
    ) u_repeat (
        .clk(clk),
        .rst_n(rst_n),
        .arm(sntp_clock_write_trigger_r),
        .fire(sntp_fire)
    );

    // all seven words are latched together so the cartridge never sees a torn time
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cart_write <= 1'b0;
            new_calendar_words <= '0;
        end
        else
        begin
            cart_write <= sntp_fire;
            if (sntp_fire)
                new_calendar_words <= sntp_time_words;
        end
    end

endmodule

// >>> core/sfb_pkg.sv
// package: constants, register map and carrier types of the special flag bank
//
// Function
// - each of four interrupt inputs has a status flag that follows its enable
// - timer interrupt status flag follows the timer interrupt enable
// - receive cancel for serial ports 4, 5, 6 disables pending receives there
// - receive cancel for serial port 7 disables pending receives there
// - three client connections each have a receive cancel flag
// - eight server connections each have a receive cancel flag
// - word compare sets greater flag when first operand exceeds second
// - word compare sets equal flag when both operands are equal
// - word compare sets less flag when first operand is below second
// - interval compare sets greater flag when middle operand exceeds upper limit
// - interval compare sets equal flag when lower limit exceeds middle operand
// - interval compare sets less flag when middle lies strictly between limits
// - catch input edge copies that input level into its flag at once
// - at most one edge is captured per catch input per scan
// - network setting words take effect only when the update flag is set
// - sntp write flag copies sntp time to cartridge, repeating every 24 hours
// - each interrupt input has an edge select flag: set rising, clear falling
// - three maintenance server connections each show an in-use flag
// - three client connections each show an in-use flag
// - eight server connections each show an in-use flag
// - client disconnect flag closes its connection while that connection is in use
// - repeated sntp write stores the same seven calendar and clock words
package sfb_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h00;
    localparam logic [7:0] OFS_CMP_RESULT = 8'h04;
    localparam logic [7:0] OFS_CATCH = 8'h08;
    localparam logic [7:0] OFS_CANCEL = 8'h0C;
    localparam logic [7:0] OFS_CTRL = 8'h10;
    localparam logic [7:0] OFS_CONN = 8'h14;
    localparam logic [7:0] OFS_DISCONNECT = 8'h18;
    localparam logic [7:0] OFS_NET_WORDS = 8'h1C;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int POS_TIMER_IRQ = 4;
    localparam int POS_CMP_LESS = 0;
    localparam int POS_CMP_EQUAL = 1;
    localparam int POS_CMP_GREATER = 2;
    localparam int POS_CANCEL_SERIAL = 0;
    localparam int POS_CANCEL_CLIENT = 4;
    localparam int POS_CANCEL_SERVER = 7;
    localparam int POS_NET_UPDATE = 0;
    localparam int POS_SNTP_WRITE = 1;
    localparam int POS_EDGE_SEL = 2;
    localparam int POS_CONN_CLIENT = 3;
    localparam int POS_CONN_SERVER = 6;

    // ------------------------------------------------------------
    // sizes and reset values
    // ------------------------------------------------------------
    localparam int N_IRQ = 4;
    localparam int N_SERIAL = 4;
    localparam int N_MAINT = 3;
    localparam int N_CLIENT = 3;
    localparam int N_SERVER = 8;
    localparam int N_TIME_WORDS = 7;
    localparam int WORD_W = 16;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // ------------------------------------------------------------
    // timing: 24 hour sntp repeat at 200 MHz
    // ------------------------------------------------------------
    localparam longint unsigned CLK_HZ = 200_000_000;
    localparam longint unsigned SNTP_REPEAT_HOURS = 24;
    localparam longint unsigned SNTP_REPEAT_CYCLES = SNTP_REPEAT_HOURS * 64'd3600 * CLK_HZ;
    localparam int REPEAT_CNT_W = 48;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        SFB_OP_WORD = 1'b0,
        SFB_OP_INTERVAL = 1'b1
    } sfb_cmp_op_t;

    typedef struct packed {
        logic valid;
        sfb_cmp_op_t op;
        logic [WORD_W-1:0] first_source_operand;
        logic [WORD_W-1:0] second_source_operand;
        logic [WORD_W-1:0] third_source_operand;
    } sfb_cmp_req_t;

    typedef struct packed {
        logic [N_MAINT-1:0] maint_server_in_use;
        logic [N_CLIENT-1:0] client_conn_in_use;
        logic [N_SERVER-1:0] server_conn_in_use;
    } sfb_conn_t;

    typedef struct packed {
        logic [N_SERIAL-1:0] serial;
        logic [N_CLIENT-1:0] client;
        logic [N_SERVER-1:0] server;
    } sfb_cancel_t;

    typedef logic [N_TIME_WORDS-1:0][WORD_W-1:0] sfb_time_words_t;

endpackage

// >>> core/sfb_repeat_timer.sv
// module: trigger pulse on arm and then once every repeat period while armed
`timescale 1ns/1ps
module sfb_repeat_timer #(
    parameter longint unsigned REPEAT_CYCLES = sfb_pkg::SNTP_REPEAT_CYCLES
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic arm,
    // event
    output logic fire
);

    logic arm_d_r;
    logic [sfb_pkg::REPEAT_CNT_W-1:0] cnt_r;
    logic wrap;

    assign wrap = (cnt_r == sfb_pkg::REPEAT_CNT_W'(REPEAT_CYCLES - 64'd1));

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            arm_d_r <= 1'b0;
        else
            arm_d_r <= arm;
    end

    // counter restarts on every arm so the period runs from the first copy
    always_ff @(posedge clk)
    begin
        if (!rst_n || !arm || !arm_d_r || wrap)
            cnt_r <= '0;
        else
            cnt_r <= cnt_r + 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            fire <= 1'b0;
        else
            fire <= arm && (!arm_d_r || wrap);
    end

endmodule

// >>> testbench/sfb_flag_bank_chk.sv
// checker: port-level properties of the special flag bank
`timescale 1ns/1ps
module sfb_flag_bank_chk #(
    parameter longint unsigned REPEAT_CYCLES = 20
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // flag side
    input wire sfb_pkg::sfb_conn_t conn_state,
    input wire sfb_pkg::sfb_cancel_t receive_cancel,
    input wire logic [sfb_pkg::N_CLIENT-1:0] client_close,
    input wire logic [sfb_pkg::N_IRQ-1:0] irq_edge_select,
    input wire logic [31:0] net_config,
    input wire logic net_apply,
    input wire logic cart_write,
    input wire sfb_pkg::sfb_time_words_t new_calendar_words
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    AST_READY_STEP: assert property (s_setup |=> s_answer)
        else $error("pready not in the access cycle");
    AST_SLVERR_MAP: assert property (pready |-> pslverr == (paddr > sfb_pkg::OFS_NET_WORDS || paddr[1:0] != 2'b00))
        else $error("pslverr does not match address map");
    AST_RESET_CLEAR: assert property ($rose(rst_n) |-> !cart_write && !net_apply && net_config == 0)
        else $error("outputs not clear after reset");
    AST_CLOSE_INUSE: assert property ((client_close & ~$past(conn_state.client_conn_in_use, 2)) == 0)
        else $error("close on a connection not in use");
    AST_NET_HOLD: assert property (!$stable(net_config) |-> $past(net_apply))
        else $error("network config changed without apply");
    AST_NET_PULSE: assert property (net_apply |=> !net_apply)
        else $error("apply longer than one cycle");
    AST_CART_PULSE: assert property (cart_write |=> !cart_write)
        else $error("cartridge write longer than one cycle");
    AST_CART_WORDS: assert property (!$stable(new_calendar_words) |-> cart_write)
        else $error("calendar words changed without write");
    AST_EDGE_WRITE: assert property (!$stable(irq_edge_select)
        |-> $past(psel && penable && pwrite && paddr == sfb_pkg::OFS_CTRL))
        else $error("edge select changed without ctrl write");
    AST_CANCEL_WRITE: assert property (!$stable(receive_cancel)
        |-> $past(psel && penable && pwrite && paddr == sfb_pkg::OFS_CANCEL))
        else $error("cancel changed without cancel write");
endmodule
bind sfb_flag_bank sfb_flag_bank_chk #(.REPEAT_CYCLES(REPEAT_CYCLES)) u_sfb_flag_bank_chk (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .conn_state(conn_state), .receive_cancel(receive_cancel), .client_close(client_close),
    .irq_edge_select(irq_edge_select), .net_config(net_config), .net_apply(net_apply), .cart_write(cart_write),
    .new_calendar_words(new_calendar_words));

// >>> testbench/sfb_flag_bank_tb_top.sv
// testbench: register-level tests of the special flag bank
`timescale 1ns/1ps
module sfb_flag_bank_tb_top;
    // short repeat period keeps the run brief
    localparam longint unsigned RPT = 20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] irq_enable = 4'h0;
    logic timer_irq_enable = 1'b0;
    sfb_pkg::sfb_cmp_req_t cmp_req = '0;
    logic [3:0] catch_in = 4'h0;
    logic scan_start = 1'b0;
    sfb_pkg::sfb_conn_t conn_state = '0;
    sfb_pkg::sfb_time_words_t sntp_time_words = '0;
    sfb_pkg::sfb_cancel_t receive_cancel;
    logic [2:0] client_close;
    logic [3:0] irq_edge_select;
    logic [31:0] net_config;
    logic net_apply;
    logic cart_write;
    sfb_pkg::sfb_time_words_t new_calendar_words;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    int carts = 0;
    int applies = 0;
    logic [31:0] rd;
    logic err;
    logic [31:0] cp [3] = '{32'hFFFF_FFFF, 32'h0000_2A5A, 32'h0};
    // op, first, second, third operand, expected greater/equal/less
    logic [51:0] ct [8] = '{{1'b0, 16'd5, 16'd3, 16'd0, 3'b100}, {1'b0, 16'd3, 16'd3, 16'd0, 3'b010},
        {1'b0, 16'd2, 16'd3, 16'd0, 3'b001}, {1'b1, 16'd10, 16'd11, 16'd2, 3'b100},
        {1'b1, 16'd10, 16'd1, 16'd2, 3'b010}, {1'b1, 16'd10, 16'd5, 16'd2, 3'b001},
        {1'b1, 16'd10, 16'd10, 16'd2, 3'b000}, {1'b1, 16'd10, 16'd2, 16'd2, 3'b000}};

    sfb_flag_bank #(.REPEAT_CYCLES(RPT)) u_sfb_flag_bank (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq_enable(irq_enable), .timer_irq_enable(timer_irq_enable), .cmp_req(cmp_req), .catch_in(catch_in),
        .scan_start(scan_start), .conn_state(conn_state), .sntp_time_words(sntp_time_words),
        .receive_cancel(receive_cancel), .client_close(client_close), .irq_edge_select(irq_edge_select),
        .net_config(net_config), .net_apply(net_apply), .cart_write(cart_write),
        .new_calendar_words(new_calendar_words));

    always #2.5 clk = ~clk;
    // pulses counted mid-cycle, away from the launching edge
    always @(negedge clk)
    begin
        carts += (cart_write === 1'b1);
        applies += (net_apply === 1'b1);
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // outputs move by nba, so the edge still shows the sampled answer
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        tick(2);
        apb(1'b0, a, 32'h0);
        chk($sformatf("read %h", a), e, rd);
    endtask
    task automatic scan();
        scan_start <= 1'b1;
        tick(1);
        scan_start <= 1'b0;
    endtask

    initial
    begin
        tick(10);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) rchk(8'(i * 4), 32'h0);
        apb(1'b1, 8'h24, 32'hFFFF_FFFF);
        chk("slverr", 32'h1, {31'h0, err});
        $display("test reset done");
        irq_enable <= 4'hA;
        timer_irq_enable <= 1'b1;
        rchk(sfb_pkg::OFS_IRQ_STATUS, 32'h1A);
        irq_enable <= 4'h5;
        timer_irq_enable <= 1'b0;
        rchk(sfb_pkg::OFS_IRQ_STATUS, 32'h05);
        conn_state <= {3'b101, 3'b011, 8'hA5};
        rchk(sfb_pkg::OFS_CONN, {18'h0, 8'hA5, 3'b011, 3'b101});
        $display("test status done");
        foreach (cp[i])
        begin
            apb(1'b1, sfb_pkg::OFS_CANCEL, cp[i]);
            tick(1);
            chk("cancel", {17'h0, cp[i][3:0], cp[i][6:4], cp[i][14:7]}, {17'h0, receive_cancel});
            rchk(sfb_pkg::OFS_CANCEL, cp[i] & 32'h7FFF);
        end
        foreach (ct[i])
        begin
            cmp_req <= {1'b1, ct[i][51:3]};
            tick(1);
            cmp_req.valid <= 1'b0;
            rchk(sfb_pkg::OFS_CMP_RESULT, {29'h0, ct[i][2:0]});
        end
        $display("test compare done");
        scan();
        catch_in <= 4'h9;
        rchk(sfb_pkg::OFS_CATCH, 32'h9);
        catch_in <= 4'h0;
        rchk(sfb_pkg::OFS_CATCH, 32'h9);
        scan();
        catch_in <= 4'h9;
        tick(3);
        scan();
        catch_in <= 4'h0;
        rchk(sfb_pkg::OFS_CATCH, 32'h0);
        $display("test catch done");
        apb(1'b1, sfb_pkg::OFS_CTRL, 32'h3C);
        tick(1);
        chk("edge select", 32'hF, {28'h0, irq_edge_select});
        apb(1'b1, sfb_pkg::OFS_NET_WORDS, 32'hC0A8_0001);
        rchk(sfb_pkg::OFS_NET_WORDS, 32'hC0A8_0001);
        chk("net config", 32'h0, net_config);
        apb(1'b1, sfb_pkg::OFS_CTRL, 32'h15);
        tick(3);
        chk("net config", 32'hC0A8_0001, net_config);
        chk("apply pulses", 32'h1, 32'(applies));
        chk("edge select", 32'h5, {28'h0, irq_edge_select});
        rchk(sfb_pkg::OFS_CTRL, 32'h14);
        $display("test control done");
        foreach (sntp_time_words[i]) sntp_time_words[i] <= 16'h2000 + 16'(i);
        apb(1'b1, sfb_pkg::OFS_CTRL, 32'h16);
        tick(5);
        chk("cartridge writes", 32'h1, 32'(carts));
        foreach (new_calendar_words[i]) chk("calendar word", 32'h2000 + i, {16'h0, new_calendar_words[i]});
        tick(int'(RPT));
        chk("cartridge writes", 32'h2, 32'(carts));
        apb(1'b1, sfb_pkg::OFS_CTRL, 32'h14);
        tick(60);
        chk("cartridge writes", 32'h2, 32'(carts));
        $display("test sntp done");
        conn_state <= {3'b000, 3'b011, 8'h00};
        apb(1'b1, sfb_pkg::OFS_DISCONNECT, 32'h6);
        tick(3);
        chk("client close", 32'h2, {29'h0, client_close});
        conn_state.client_conn_in_use <= 3'b001;
        tick(3);
        chk("client close", 32'h0, {29'h0, client_close});
        rchk(sfb_pkg::OFS_DISCONNECT, 32'h6);
        $display("test disconnect done");
        complete_run();
    end
endmodule
